//--- hw/cam_cfg.svh
// Purpose: constants for the content addressable memory pair
// Assumes: included by bare name after the package
// Notes:   field widths and cycle counts live here as macros
`ifndef CAM_CFG_SVH
`define CAM_CFG_SVH

`define CAM_WORDS        32
`define CAM_WIDTH        32
`define CAM_IDX_W        5
`define CAM_LINES        16
`define CAM_WR_CYCLES    2
`define CAM_WR_CYCLES_DC 3

`endif

//--- hw/cam_pkg.sv
// Purpose: shared types for the content addressable memory pair
// Assumes: widths match cam_cfg.svh
// Notes:   types only; numbers stay in the header
package cam_pkg;

   typedef enum logic {
      CAM_FMT_ENCODED,
      CAM_FMT_UNENCODED
   } cam_fmt_t;

   typedef enum logic [1:0] {
      CAM_WR_IDLE,
      CAM_WR_DATA,
      CAM_WR_MASK,
      CAM_WR_DONE
   } cam_wr_state_t;

endpackage

//--- hw/cam_link_if.sv
// Purpose: carrier joining the memory end and the user end
// Assumes: one clock, synchronous reset outside
// Notes:   no clocking block; testbench joins the two modports
`timescale 1ns/10ps
`include "cam_cfg.svh"

interface cam_link_if;
   // search request and result
   logic                         srch_valid;
   logic [`CAM_WIDTH-1:0]        srch_data;
   logic                         fmt_unenc;
   logic                         res_valid;
   logic                         res_match;
   logic [`CAM_IDX_W-1:0]        res_index;
   logic [`CAM_LINES-1:0]        res_lines;
   logic                         res_half;
   // word writes
   logic                         wr_req;
   logic [`CAM_IDX_W-1:0]        wr_addr;
   logic [`CAM_WIDTH-1:0]        wr_data;
   logic [`CAM_WIDTH-1:0]        wr_care;
   logic                         wr_dc;
   logic                         wr_done;

   modport mem
   (
      input  srch_valid, srch_data, fmt_unenc, wr_req, wr_addr, wr_data, wr_care, wr_dc,
      output res_valid, res_match, res_index, res_lines, res_half, wr_done
   );
   modport user
   (
      output srch_valid, srch_data, fmt_unenc, wr_req, wr_addr, wr_data, wr_care, wr_dc,
      input  res_valid, res_match, res_index, res_lines, res_half, wr_done
   );
endinterface

//--- hw/cam_match_word.sv
// Purpose: one stored word with its care mask and compare
// Assumes: written by the memory end, one clock
// Notes:   care bit low marks a do-not-care bit
`timescale 1ns/10ps
`include "cam_cfg.svh"

module cam_match_word
#(
   parameter int                 WIDTH = `CAM_WIDTH,
   parameter logic [WIDTH-1:0]   INIT_DATA = '0,
   parameter logic [WIDTH-1:0]   INIT_CARE = '1
)
(
   // clock
   input  wire logic             sys_clk_i,
   // write strobes
   input  wire logic             data_we_i,
   input  wire logic             care_we_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic [WIDTH-1:0] wr_care_i,
   // compare
   input  wire logic [WIDTH-1:0] key_i,
   output logic                  hit_o
);
   // contents are not reset: they come from configuration preload
   logic [WIDTH-1:0] data_ff = INIT_DATA;
   logic [WIDTH-1:0] care_ff = INIT_CARE;

   always_ff @(posedge sys_clk_i)
   begin
      if (data_we_i)
      begin
         data_ff <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (care_we_i)
      begin
         care_ff <= wr_care_i;
      end
   end

   assign hit_o = (((data_ff ^ key_i) & care_ff) == '0);
endmodule

//--- hw/cam_mem_end.sv
// Purpose: content addressable memory end: store, search and report matches
// Assumes: user end keeps the write request high until wr_done
// Notes:   stored words are never reset; their preload comes from configuration
//          a search met while the first beat is shown is dropped, not queued
// Notes on behaviour
// - thirty-two words of thirty-two bits, all compared
// - do-not-care bits never affect a match
// - result format selectable: encoded or unencoded
// - encoded result is the matching word index
// - unencoded result drives sixteen match lines
// - unencoded vector spans two cycles, reader takes both
// - writer avoids duplicate words when using encoded form
// - unencoded form flags every matching location
// - preloaded at configuration, writable during operation
// - plain write takes two cycles, request held
// - write with do-not-care bits takes three cycles
`timescale 1ns/10ps
`include "cam_cfg.svh"

module cam_mem_end
#(
   parameter int WORDS = `CAM_WORDS,
   parameter int WIDTH = `CAM_WIDTH,
   parameter int IDX_W = `CAM_IDX_W,
   parameter int LINES = `CAM_LINES
)
(
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   // link to the user end
   cam_link_if.mem   lnk
);
   //--------------------------------------------------------------
   // storage and compare
   //--------------------------------------------------------------
   logic [WORDS-1:0] hit;
   logic [WORDS-1:0] data_we;
   logic [WORDS-1:0] care_we;
   cam_pkg::cam_wr_state_t wr_state_ff;
   cam_pkg::cam_wr_state_t nxt_wr_state;

   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi++)
      begin : g_word
         // every word sees the same key; initial contents preloaded
         cam_match_word #(.WIDTH(WIDTH)) u_word
         (
            .sys_clk_i (sys_clk_i),
            .data_we_i (data_we[gi]),
            .care_we_i (care_we[gi]),
            .wr_data_i (lnk.wr_data),
            .wr_care_i (lnk.wr_care),
            .key_i     (lnk.srch_data),
            .hit_o     (hit[gi])
         );
         assign data_we[gi] = (wr_state_ff == cam_pkg::CAM_WR_DATA)
                              && (lnk.wr_addr == IDX_W'(gi));
         // mask goes in with the data; a clean write resets it to all care
         assign care_we[gi] = data_we[gi];
      end
   endgenerate

   //--------------------------------------------------------------
   // write sequencer
   //--------------------------------------------------------------
   // the mask lands with the data; the extra masked cycle is timing only
   always_comb
   begin
      nxt_wr_state = wr_state_ff;
      case (wr_state_ff)
         cam_pkg::CAM_WR_IDLE:
            if (lnk.wr_req)
               nxt_wr_state = cam_pkg::CAM_WR_DATA;
         cam_pkg::CAM_WR_DATA:
            nxt_wr_state = lnk.wr_dc ? cam_pkg::CAM_WR_MASK : cam_pkg::CAM_WR_DONE;
         cam_pkg::CAM_WR_MASK:
            nxt_wr_state = cam_pkg::CAM_WR_DONE;
         cam_pkg::CAM_WR_DONE:
            nxt_wr_state = cam_pkg::CAM_WR_IDLE;
         default:
            nxt_wr_state = cam_pkg::CAM_WR_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         wr_state_ff <= cam_pkg::CAM_WR_IDLE;
      else
         wr_state_ff <= nxt_wr_state;
   end

   // data is taken in the first cycle; done marks the end of cycle two or three
   // so the request must stand until then
   assign lnk.wr_done = (wr_state_ff == cam_pkg::CAM_WR_DONE);

   //--------------------------------------------------------------
   // result formatting
   //--------------------------------------------------------------
   logic [IDX_W-1:0] enc_idx;
   always_comb
   begin
      enc_idx = '0;
      // highest index wins; duplicates make this ambiguous
      for (int i = 0; i < WORDS; i++)
      begin
         if (hit[i])
         begin
            enc_idx = IDX_W'(i);
         end
      end
   end

   // both halves of the hit vector, named for the two beats
   logic [LINES-1:0]      hit_lo;
   logic [LINES-1:0]      hit_hi;
   logic                  any_hit;

   assign hit_lo  = hit[LINES-1:0];
   assign hit_hi  = hit[WORDS-1:LINES];
   assign any_hit = |hit;

   logic                  res_valid_ff;
   logic                  res_match_ff;
   logic [IDX_W-1:0]      res_index_ff;
   logic [LINES-1:0]      res_lines_ff;
   logic                  res_half_ff;
   logic [LINES-1:0]      upper_ff;
   logic                  upper_pend_ff;
   logic                  take_srch;

   // a search met while the first beat is shown is dropped
   assign take_srch = lnk.srch_valid && !upper_pend_ff;

   // second beat always follows the first in the next cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         upper_pend_ff <= 1'b0;
      else
         upper_pend_ff <= take_srch && lnk.fmt_unenc;
   end

   // high half waits here for its beat; no buffer beyond that
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         upper_ff <= '0;
      else if (take_srch && lnk.fmt_unenc)
         upper_ff <= hit_hi;
   end

   // search sampled at this edge, result shown from the next
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         res_valid_ff <= 1'b0;
      else
         res_valid_ff <= take_srch || upper_pend_ff;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         res_half_ff <= 1'b0;
      else
         res_half_ff <= upper_pend_ff;
   end

   // flag kept through the second beat so it speaks for both halves
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         res_match_ff <= 1'b0;
      else if (take_srch)
         res_match_ff <= any_hit;
   end

   // index cleared in unencoded form so a stale value is never shown
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         res_index_ff <= '0;
      else if (take_srch)
         res_index_ff <= lnk.fmt_unenc ? '0 : enc_idx;
   end

   // low half first, high half on the following beat
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         res_lines_ff <= '0;
      else if (upper_pend_ff)
         res_lines_ff <= upper_ff;
      else if (take_srch)
         res_lines_ff <= lnk.fmt_unenc ? hit_lo : '0;
   end

   assign lnk.res_valid = res_valid_ff;
   assign lnk.res_match = res_match_ff;
   assign lnk.res_index = res_index_ff;
   assign lnk.res_lines = res_lines_ff;
   assign lnk.res_half  = res_half_ff;
endmodule

//--- hw/cam_user_end.sv
// Purpose: user end: issues searches and writes, gathers results
// Assumes: memory end on the same clock
// Notes:   one operation at a time; busy_o shows when it can take another
`timescale 1ns/10ps
`include "cam_cfg.svh"

module cam_user_end
(
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   reset_i,
   // user commands
   input  wire logic                   srch_i,
   input  wire logic [`CAM_WIDTH-1:0]  srch_data_i,
   input  wire logic                   fmt_unenc_i,
   input  wire logic                   wr_i,
   input  wire logic [`CAM_IDX_W-1:0]  wr_addr_i,
   input  wire logic [`CAM_WIDTH-1:0]  wr_data_i,
   input  wire logic [`CAM_WIDTH-1:0]  wr_care_i,
   output logic                        busy_o,
   // results
   output logic                        done_o,
   output logic                        match_o,
   output logic [`CAM_IDX_W-1:0]       index_o,
   output logic [`CAM_WORDS-1:0]       vector_o,
   // link
   cam_link_if.user                    lnk
);
   logic                      wr_act_ff;
   logic [`CAM_IDX_W-1:0]     wr_addr_ff;
   logic [`CAM_WIDTH-1:0]     wr_data_ff;
   logic [`CAM_WIDTH-1:0]     wr_care_ff;
   logic                      srch_busy_ff;
   logic                      done_ff;
   logic                      match_ff;
   logic [`CAM_IDX_W-1:0]     index_ff;
   logic [`CAM_WORDS-1:0]     vector_ff;
   logic                      srch_valid_ff;
   logic [`CAM_WIDTH-1:0]     srch_data_ff;
   logic                      fmt_ff;
   logic                      srch_take;

   assign busy_o    = wr_act_ff | srch_busy_ff;
   assign srch_take = srch_i && !busy_o && !wr_i;

   // key and format leave from flip-flops; format holds until the next search
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         srch_valid_ff <= 1'b0;
      else
         srch_valid_ff <= srch_take;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         srch_data_ff <= '0;
         fmt_ff       <= 1'b0;
      end
      else if (srch_take)
      begin
         srch_data_ff <= srch_data_i;
         fmt_ff       <= fmt_unenc_i;
      end
   end

   // request stands until the memory end reports done
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         wr_act_ff <= 1'b0;
      else if (lnk.wr_done)
         wr_act_ff <= 1'b0;
      else if (wr_i && !busy_o)
         wr_act_ff <= 1'b1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (wr_i && !busy_o)
      begin
         wr_addr_ff <= wr_addr_i;
         wr_data_ff <= wr_data_i;
         wr_care_ff <= wr_care_i;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         srch_busy_ff <= 1'b0;
      else if (srch_take)
         srch_busy_ff <= 1'b1;
      else if (lnk.res_valid && (lnk.res_half || !fmt_ff))
         srch_busy_ff <= 1'b0;
   end

   assign lnk.wr_req     = wr_act_ff;
   assign lnk.wr_addr    = wr_addr_ff;
   assign lnk.wr_data    = wr_data_ff;
   assign lnk.wr_care    = wr_care_ff;
   assign lnk.wr_dc      = ~&wr_care_ff;
   assign lnk.srch_valid = srch_valid_ff;
   assign lnk.srch_data  = srch_data_ff;
   assign lnk.fmt_unenc  = fmt_ff;

   // gather both halves before reporting
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         done_ff   <= 1'b0;
         match_ff  <= 1'b0;
         index_ff  <= '0;
         vector_ff <= '0;
      end
      else
      begin
         done_ff <= 1'b0;
         if (lnk.res_valid && !lnk.res_half)
         begin
            match_ff  <= lnk.res_match;
            index_ff  <= lnk.res_index;
            vector_ff <= {{`CAM_LINES{1'b0}}, lnk.res_lines};
            done_ff   <= !fmt_ff;
         end
         else if (lnk.res_valid && lnk.res_half)
         begin
            vector_ff[`CAM_WORDS-1:`CAM_LINES] <= lnk.res_lines;
            done_ff <= 1'b1;
         end
      end
   end

   assign done_o   = done_ff;
   assign match_o  = match_ff;
   assign index_o  = index_ff;
   assign vector_o = vector_ff;
endmodule

//--- dv/cam_link_asserts.sv
// Purpose: checker on the link between the memory end and the user end
// Assumes: one clock, synchronous active-high reset
// Notes:   sees the carrier signals only; no bind
`timescale 1ns/10ps
`include "cam_cfg.svh"

module cam_link_asserts
(
   // clock and reset
   input wire logic                  sys_clk_i,
   input wire logic                  reset_i,
   // search and result
   input wire logic                  srch_valid,
   input wire logic [`CAM_WIDTH-1:0] srch_data,
   input wire logic                  fmt_unenc,
   input wire logic                  res_valid,
   input wire logic                  res_match,
   input wire logic [`CAM_IDX_W-1:0] res_index,
   input wire logic [`CAM_LINES-1:0] res_lines,
   input wire logic                  res_half,
   // word writes
   input wire logic                  wr_req,
   input wire logic [`CAM_IDX_W-1:0] wr_addr,
   input wire logic [`CAM_WIDTH-1:0] wr_data,
   input wire logic [`CAM_WIDTH-1:0] wr_care,
   input wire logic                  wr_dc,
   input wire logic                  wr_done
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   // ----------------------------------------
   // searches
   // ----------------------------------------
   property p_enc_beat;
      srch_valid && !fmt_unenc && !res_valid |=> res_valid && !res_half;
   endproperty
   a_enc_beat: assert property (p_enc_beat)
      else $error("encoded result missing one cycle after search");

   property p_unenc_beats;
      srch_valid && fmt_unenc && !res_valid |=> res_valid && !res_half ##1 res_valid && res_half;
   endproperty
   a_unenc_beats: assert property (p_unenc_beats)
      else $error("unencoded result not two back to back beats");

   // a second beat must follow a first beat directly
   property p_half_order;
      res_half |-> res_valid && $past(res_valid) && !$past(res_half);
   endproperty
   a_half_order: assert property (p_half_order)
      else $error("second beat without a first beat before it");

   property p_lines_match;
      res_valid && fmt_unenc && res_lines != '0 |-> res_match;
   endproperty
   a_lines_match: assert property (p_lines_match)
      else $error("match lines high but no match flag");

   // ----------------------------------------
   // writes
   // ----------------------------------------
   property p_wr_clean;
      $rose(wr_req) && !wr_dc |-> !wr_done ##1 !wr_done ##1 wr_done;
   endproperty
   a_wr_clean: assert property (p_wr_clean)
      else $error("plain write not done in two cycles");

   property p_wr_dc;
      $rose(wr_req) && wr_dc |-> !wr_done [*3] ##1 wr_done;
   endproperty
   a_wr_dc: assert property (p_wr_dc)
      else $error("masked write not done in three cycles");

   property p_wr_hold;
      wr_req && !wr_done |=> wr_req && $stable(wr_addr) && $stable(wr_data) && $stable(wr_care);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write request changed before done");

   property p_wr_release;
      wr_done |=> !wr_req && !wr_done;
   endproperty
   a_wr_release: assert property (p_wr_release)
      else $error("write request or done held after done");

   property p_dc_flag;
      wr_req |-> wr_dc == (wr_care != '1);
   endproperty
   a_dc_flag: assert property (p_dc_flag)
      else $error("mask flag disagrees with care bits");

   c_unenc: cover property (res_valid && res_half);
   c_dc_write: cover property (wr_done && wr_dc);
   c_enc_twelve: cover property (res_valid && !fmt_unenc && res_match && res_index == 5'h0C);
   c_zero_key: cover property (srch_valid && srch_data == '0);
endmodule

//--- dv/tb.sv
// Purpose: joins both ends of the memory link and checks search results
// Assumes: user end takes a command while busy_o is low
// Notes:   expected results come from a word model kept here
`timescale 1ns/10ps
`include "cam_cfg.svh"

module tb;
   typedef struct packed {logic u; logic m; logic [4:0] x; logic [31:0] v;} cam_note_t;

   logic        sys_clk_i   = 1'b0;
   logic        reset_i     = 1'b1;
   logic        srch_i      = 1'b0;
   logic        fmt_unenc_i = 1'b0;
   logic        wr_i        = 1'b0;
   logic [31:0] srch_data_i = '0;
   logic [31:0] wr_data_i   = '0;
   logic [31:0] wr_care_i   = '0;
   logic [4:0]  wr_addr_i   = '0;
   logic        busy_o;
   logic        done_o;
   logic        match_o;
   logic [4:0]  index_o;
   logic [31:0] vector_o;
   logic [31:0] m_data [32];
   logic [31:0] m_care [32];
   logic [31:0] w      [32];
   cam_note_t   exp_q  [$];
   cam_note_t   got_n;
   int          errors  = 0;
   int          checked = 0;

   always #10 sys_clk_i = ~sys_clk_i;

   cam_link_if cam_link_if_i ();
   cam_mem_end cam_mem_end_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .lnk(cam_link_if_i));
   cam_user_end cam_user_end_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .srch_i(srch_i),
      .srch_data_i(srch_data_i), .fmt_unenc_i(fmt_unenc_i), .wr_i(wr_i), .wr_addr_i(wr_addr_i),
      .wr_data_i(wr_data_i), .wr_care_i(wr_care_i), .busy_o(busy_o), .done_o(done_o),
      .match_o(match_o), .index_o(index_o), .vector_o(vector_o), .lnk(cam_link_if_i));
   cam_link_asserts cam_link_asserts_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .srch_valid(cam_link_if_i.srch_valid), .srch_data(cam_link_if_i.srch_data),
      .fmt_unenc(cam_link_if_i.fmt_unenc), .res_valid(cam_link_if_i.res_valid),
      .res_match(cam_link_if_i.res_match), .res_index(cam_link_if_i.res_index),
      .res_lines(cam_link_if_i.res_lines), .res_half(cam_link_if_i.res_half),
      .wr_req(cam_link_if_i.wr_req), .wr_addr(cam_link_if_i.wr_addr),
      .wr_data(cam_link_if_i.wr_data), .wr_care(cam_link_if_i.wr_care),
      .wr_dc(cam_link_if_i.wr_dc), .wr_done(cam_link_if_i.wr_done));

   // ----------------------------------------
   // compare and report
   // ----------------------------------------
   task automatic chk_match(input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD match expected %b seen %b", e, g);
      end
   endtask

   task automatic chk_index(input logic [4:0] e, input logic [4:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD index expected %0d seen %0d", e, g);
      end
   endtask

   task automatic chk_vector(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD vector expected %h seen %h", e, g);
      end
   endtask

   task automatic complete_run();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic step();
      @(posedge sys_clk_i);
      #1;
   endtask

   // also waits for every noted result, so the format level never moves under a search
   task automatic wait_idle();
      int n;
      n = 0;
      while ((busy_o !== 1'b0 || exp_q.size() != 0) && n < 100)
      begin
         step();
         n++;
      end
      if (n == 100)
      begin
         errors++;
         $display("BAD idle expected 0 seen %b", busy_o);
      end
   endtask

   task automatic do_write(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c);
      wait_idle();
      wr_i = 1'b1;
      wr_addr_i = a;
      wr_data_i = d;
      wr_care_i = c;
      step();
      wr_i = 1'b0;
      m_data[a] = d;
      m_care[a] = c;
   endtask

   task automatic do_search(input logic [31:0] k, input logic u);
      cam_note_t e;
      wait_idle();
      e = '0;
      e.u = u;
      for (int i = 0; i < 32; i++)
      begin
         e.v[i] = ((k ^ m_data[i]) & m_care[i]) == '0;
         if (e.v[i])
            e.x = 5'(i);
      end
      e.m = |e.v;
      exp_q.push_back(e);
      srch_i = 1'b1;
      srch_data_i = k;
      fmt_unenc_i = u;
      step();
      srch_i = 1'b0;
   endtask

   always @(posedge sys_clk_i)
   begin
      if (done_o === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            errors++;
            $display("BAD done expected 0 seen 1");
         end
         else
         begin
            got_n = exp_q.pop_front();
            chk_match(got_n.m, match_o);
            if (got_n.u)
               chk_vector(got_n.v, vector_o);
            else if (got_n.m)
               chk_index(got_n.x, index_o);
         end
      end
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      void'($urandom(67799));
      for (int i = 0; i < 32; i++)
      begin
         m_data[i] = '0;
         m_care[i] = '1;
      end
      repeat (8) @(posedge sys_clk_i);
      #1;
      reset_i = 1'b0;
      do_search(32'h0, 1'b1);
      do_search(32'h0, 1'b0);
      wait_idle();
      $display("test preload done");
      for (int i = 0; i < 32; i++)
      begin
         w[i] = ($urandom() & 32'hFFFF_FFE0) | 32'(i);
         do_write(5'(i), w[i], '1);
      end
      for (int i = 0; i < 32; i++)
      begin
         do_search(w[i], 1'b0);
         do_search(w[i], 1'b1);
      end
      wait_idle();
      $display("test write and search done");
      do_write(5'h0C, w[12], 32'hFFFF_FF00);
      do_search(w[12] ^ 32'h0000_00A5, 1'b0);
      do_search(w[12] ^ 32'h0000_005A, 1'b1);
      wait_idle();
      $display("test masked bits done");
      do_write(5'h05, w[20], '1);
      do_search(w[20], 1'b1);
      do_search(w[20], 1'b0);
      do_search(~w[3], 1'b0);
      do_search(~w[3], 1'b1);
      do_search($urandom(), 1'b1);
      wait_idle();
      $display("test duplicate and miss done");
      complete_run();
   end

   // bound: about 500 cycles of traffic, cut off at forty times that
   initial
   begin
      #(20 * 20000);
      errors++;
      $display("BAD watchdog expected finish seen hang");
      complete_run();
   end
endmodule
